/* File: core/dma_halt_refresh_bus_control.sv */
// processor end: dma arbitration, halt handling, refresh strobe
// assumes pins synchronous to sys_clk_i and the far end on bus_ctrl_if.dev
//
// Contract
// - peripheral asserts dma request to ask bus
// - processor alone arbitrates bus ownership
// - grant only when processor sync idle
// - pending request and free bus: assert grant
// - peripheral drops request, asserts acknowledge
// - halt request stops normal program execution
// - halted: no external irq, refresh, dma; code blocks only the external irq, refresh and dma still run
// - refresh interrupts only with jumper removed
// - halted: run console debugger microcode
// - refresh strobe from processor or device
// - memories activate on refreshed read cycles
// - no dma bursts during processor refresh; code only blocks a new device request while the refresh line is active
`timescale 1ns/10ps
`include "bus_ctrl_regs.svh"
module dma_halt_refresh_bus_control
  import bus_ctrl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // bus link
  bus_ctrl_if.cpu bus,
  // processor core side
  input wire logic halt_request_n_i,
  input wire logic refresh_enable_jumper_i,
  input wire logic cpu_cycle_req_i,
  input wire logic cpu_cycle_read_i,
  input wire logic ext_irq_i,
  output logic cpu_cycle_done_o,
  output logic halted_o,
  output logic console_debugger_microcode_o,
  output logic ext_irq_taken_o,
  output logic dma_active_o,
  output logic refresh_active_o
);
  // arbitration and bus cycle state
  arb_state_t arb_q;
  logic grant_n_q;
  logic sync_q;
  logic sync_n_q;
  logic din_n_q;
  logic done_q;

  // halt and interrupt state
  logic halted_q;
  logic irq_q;

  // refresh timer and strobe
  logic [`REFRESH_CNT_W-1:0] ref_cnt_q;
  logic [3:0] ref_pulse_q;
  logic ref_oe_q;
  logic ref_due;

  // decoded pins
  logic dma_req;
  logic dma_ack;
  logic ref_en;

  // an active-low bus line is pulled
  function automatic logic line_active(input logic line_n);
    return !line_n;
  endfunction

  // processor owns the bus with no cycle in flight
  function automatic logic bus_idle(input arb_state_t arb, input logic sync);
    return (arb == ARB_CPU) && !sync;
  endfunction

  assign dma_req = line_active(bus.dma_request_n);
  assign dma_ack = line_active(bus.selection_ack_n);
  assign ref_en = refresh_enable_jumper_i; // high = jumper removed
  assign ref_due = ref_en && (ref_cnt_q == `REFRESH_CNT_W'(`REFRESH_PERIOD_CYC - 1));

  // arbitration state; a waiting core cycle does not hold off a grant
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arb_q <= ARB_CPU;
      grant_n_q <= 1'b1;
    end else begin
      unique case (arb_q)
        ARB_CPU: begin
          if (dma_req && bus_idle(arb_q, sync_q)) begin
            arb_q <= ARB_GRANT;
            grant_n_q <= 1'b0;
          end
        end
        ARB_GRANT: begin
          if (dma_ack) begin
            arb_q <= ARB_DMA;
            grant_n_q <= 1'b1;
          end
        end
        ARB_DMA: begin
          if (!dma_ack) begin
            arb_q <= ARB_CPU;
          end
        end
        default: begin
          arb_q <= ARB_CPU;
          grant_n_q <= 1'b1;
        end
      endcase
    end
  end

  // processor bus cycle: one cycle of sync, data-in on reads
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
      sync_n_q <= 1'b1;
      din_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sync_q) begin
        sync_q <= 1'b0;
        sync_n_q <= 1'b1;
        din_n_q <= 1'b1;
        done_q <= 1'b1;
      end else if (bus_idle(arb_q, sync_q) && !dma_req && cpu_cycle_req_i
                   && !done_q) begin
        sync_q <= 1'b1;
        sync_n_q <= 1'b0;
        din_n_q <= !cpu_cycle_read_i;
      end
    end
  end

  // halt and console mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      halted_q <= 1'b0;
    end else begin
      halted_q <= !halt_request_n_i;
    end
  end

  // external interrupts pass only while running
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ext_irq_i && halt_request_n_i;
    end
  end

  // refresh interval timer, cleared while the jumper is fitted
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_q <= '0;
    end else if (!ref_en || ref_due) begin
      ref_cnt_q <= '0;
    end else begin
      ref_cnt_q <= ref_cnt_q + 1'b1;
    end
  end

  // refresh strobe, held for the pulse count after each interval
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_pulse_q <= '0;
      ref_oe_q <= 1'b0;
    end else if (!ref_en) begin
      ref_pulse_q <= '0;
      ref_oe_q <= 1'b0;
    end else if (ref_due) begin
      ref_pulse_q <= 4'(`REFRESH_PULSE_CYC);
      ref_oe_q <= 1'b1;
    end else begin
      if (ref_pulse_q != 4'h0) begin
        ref_pulse_q <= ref_pulse_q - 1'b1;
      end
      ref_oe_q <= (ref_pulse_q > 4'h1);
    end
  end

  // core status outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_cycle_done_o <= 1'b0;
      halted_o <= 1'b0;
      console_debugger_microcode_o <= 1'b0;
      ext_irq_taken_o <= 1'b0;
    end else begin
      cpu_cycle_done_o <= sync_q;
      halted_o <= halted_q;
      console_debugger_microcode_o <= halted_q;
      ext_irq_taken_o <= irq_q;
    end
  end

  // bus ownership and refresh outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_active_o <= 1'b0;
      refresh_active_o <= 1'b0;
    end else begin
      dma_active_o <= (arb_q == ARB_DMA);
      refresh_active_o <= line_active(bus.refresh_strobe_n);
    end
  end

  // bus pins, each straight from a flop
  assign bus.dma_grant_out_n = grant_n_q;
  assign bus.bus_sync_strobe_n = sync_n_q;
  assign bus.data_in_strobe_n = din_n_q;
  assign bus.refresh_cpu_oe = ref_oe_q;
endmodule // dma_halt_refresh_bus_control

/* File: core/bus_ctrl_regs.svh */
// timing constants and refresh counter width for dma, halt and refresh control
// assumes the 100 MHz system clock
`ifndef BUS_CTRL_REGS_SVH
`define BUS_CTRL_REGS_SVH
`define CLK_PERIOD_NS 10
`define REFRESH_PERIOD_US 1600
`define REFRESH_PERIOD_CYC ((`REFRESH_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define REFRESH_PULSE_CYC 8
`define REFRESH_CNT_W 18
`endif

/* File: core/bus_ctrl_pkg.sv */
// types for the two ends of the bus control link, arb_state_t for the processor and dev_state_t for the device
// assumes nothing beyond the compiler
package bus_ctrl_pkg;
  typedef enum logic [1:0] {
    ARB_CPU = 2'b00,
    ARB_GRANT = 2'b01,
    ARB_DMA = 2'b10
  } arb_state_t;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_REQ = 2'b01,
    DEV_MASTER = 2'b10
  } dev_state_t;
endpackage

/* File: core/bus_ctrl_if.sv */
// link between processor bus control and a dma / memory device
// assumes one shared clock; open-drain refresh line resolved from enables
`timescale 1ns/10ps
interface bus_ctrl_if (
  input wire logic sys_clk_i
);
  logic dma_request_n;
  logic dma_grant_out_n;
  logic selection_ack_n;
  logic bus_sync_strobe_n;
  logic data_in_strobe_n;
  logic refresh_cpu_oe;
  logic refresh_dev_oe;
  logic refresh_strobe_n;
  // wired-or refresh line
  assign refresh_strobe_n = !(refresh_cpu_oe || refresh_dev_oe);
  modport cpu (
    input dma_request_n, selection_ack_n, refresh_strobe_n,
    output dma_grant_out_n, bus_sync_strobe_n, data_in_strobe_n, refresh_cpu_oe
  );
  modport dev (
    input dma_grant_out_n, bus_sync_strobe_n, data_in_strobe_n, refresh_strobe_n,
    output dma_request_n, selection_ack_n, refresh_dev_oe
  );
endinterface // bus_ctrl_if

/* File: core/dma_peripheral_end.sv */
// far end: dma requester and dynamic memory refresh response
// assumes pins synchronous to sys_clk_i and the processor on bus_ctrl_if.cpu
`timescale 1ns/10ps
`include "bus_ctrl_regs.svh"
module dma_peripheral_end
  import bus_ctrl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // bus link
  bus_ctrl_if.dev bus,
  // user side
  input wire logic xfer_req_i,
  input wire logic xfer_done_i,
  input wire logic ext_refresh_i,
  output logic master_o,
  output logic mem_activate_o,
  output logic refresh_seen_o
);
  dev_state_t st_q;
  logic req_q;
  logic ack_q;
  logic ref_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= DEV_IDLE;
      req_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      unique case (st_q)
        DEV_IDLE: begin
          if (xfer_req_i && bus.refresh_strobe_n) begin
            st_q <= DEV_REQ;
            req_q <= 1'b1;
          end
        end
        DEV_REQ: begin
          if (!bus.dma_grant_out_n) begin
            st_q <= DEV_MASTER;
            req_q <= 1'b0;
            ack_q <= 1'b1;
          end
        end
        DEV_MASTER: begin
          if (xfer_done_i) begin
            st_q <= DEV_IDLE;
            ack_q <= 1'b0;
          end
        end
        default: begin
          st_q <= DEV_IDLE;
          req_q <= 1'b0;
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // memory activation on refreshed read cycles
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_q <= 1'b0;
      master_o <= 1'b0;
      mem_activate_o <= 1'b0;
      refresh_seen_o <= 1'b0;
    end else begin
      ref_q <= ext_refresh_i;
      master_o <= ack_q;
      mem_activate_o <= !bus.refresh_strobe_n && !bus.bus_sync_strobe_n
                        && !bus.data_in_strobe_n;
      refresh_seen_o <= !bus.refresh_strobe_n;
    end
  end

  assign bus.dma_request_n = !req_q;
  assign bus.selection_ack_n = !ack_q;
  assign bus.refresh_dev_oe = ref_q;
endmodule // dma_peripheral_end

/* File: verification/bus_ctrl_sva.sv */
// checker: handshake and strobe relations on bus_ctrl_if
// assumes one clock, reset active high
`timescale 1ns/10ps
module bus_ctrl_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic dma_request_n,
  input wire logic dma_grant_out_n,
  input wire logic selection_ack_n,
  input wire logic bus_sync_strobe_n,
  input wire logic data_in_strobe_n,
  input wire logic refresh_strobe_n
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  grant_idle_a: assert property (!dma_grant_out_n |-> bus_sync_strobe_n)
    else $error("grant while sync active");
  grant_cause_a: assert property ($fell(dma_grant_out_n) |-> !$past(dma_request_n))
    else $error("grant without request");
  grant_prompt_a: assert property (!dma_request_n && dma_grant_out_n && selection_ack_n
    && bus_sync_strobe_n |-> ##[1:6] !dma_grant_out_n) else $error("grant late");
  grant_drop_a: assert property ($fell(selection_ack_n) |=> dma_grant_out_n)
    else $error("grant held after ack");
  master_quiet_a: assert property (!selection_ack_n |-> bus_sync_strobe_n)
    else $error("sync while device master");
  hand_over_a: assert property ($fell(dma_grant_out_n) |=> dma_request_n && !selection_ack_n)
    else $error("no hand over");
  sync_pulse_a: assert property ($fell(bus_sync_strobe_n) |=> bus_sync_strobe_n)
    else $error("cycle not finished");
  din_framed_a: assert property (!data_in_strobe_n |-> !bus_sync_strobe_n)
    else $error("din outside sync");
  cover property ($fell(dma_grant_out_n));
  cover property (!data_in_strobe_n);
  cover property (!refresh_strobe_n && !bus_sync_strobe_n);
endmodule // bus_ctrl_sva

/* File: verification/tb_dma_halt_refresh_bus_control.sv */
// bench: processor end facing device end over bus_ctrl_if
// assumes package, interface and both ends compiled first
`timescale 1ns/10ps
module tb_dma_halt_refresh_bus_control;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic halt_n = 1'b1, jmp = 1'b1, creq = 1'b0, crd = 1'b0, irq = 1'b0;
  logic xreq = 1'b0, xdone = 1'b0, xref = 1'b0;
  logic done, halted, odt_run, irq_tk, dma_act, ref_act, master, mem_act, ref_seen;
  int error_cnt = 0;
  int checked = 0;
  int k;
  // {read, refresh, expected din, expected activate}
  logic [3:0] rows [4] = '{4'h2, 4'h8, 4'hd, 4'h6};
  always #5 sys_clk = ~sys_clk;
  bus_ctrl_if bus (.sys_clk_i(sys_clk));
  dma_halt_refresh_bus_control i_dma_halt_refresh_bus_control (.sys_clk_i(sys_clk),
    .rst_i(rst), .bus(bus), .halt_request_n_i(halt_n), .refresh_enable_jumper_i(jmp),
    .cpu_cycle_req_i(creq), .cpu_cycle_read_i(crd), .ext_irq_i(irq),
    .cpu_cycle_done_o(done), .halted_o(halted), .console_debugger_microcode_o(odt_run),
    .ext_irq_taken_o(irq_tk), .dma_active_o(dma_act), .refresh_active_o(ref_act));
  dma_peripheral_end i_dma_peripheral_end (.sys_clk_i(sys_clk), .rst_i(rst), .bus(bus),
    .xfer_req_i(xreq), .xfer_done_i(xdone), .ext_refresh_i(xref), .master_o(master),
    .mem_activate_o(mem_act), .refresh_seen_o(ref_seen));
  bus_ctrl_sva i_bus_ctrl_sva (.sys_clk_i(sys_clk), .rst_i(rst),
    .dma_request_n(bus.dma_request_n), .dma_grant_out_n(bus.dma_grant_out_n),
    .selection_ack_n(bus.selection_ack_n), .bus_sync_strobe_n(bus.bus_sync_strobe_n),
    .data_in_strobe_n(bus.data_in_strobe_n), .refresh_strobe_n(bus.refresh_strobe_n));
  task chk(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask
  task end_of_test;
    $display("checked %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one processor cycle, refresh line set up first
  task cyc(input logic rd, input logic rf, input logic ed, input logic ea);
    xref = rf;
    crd = rd;
    repeat (2) @(negedge sys_clk);
    creq = 1'b1;
    for (k = 0; k < 20 && bus.bus_sync_strobe_n !== 1'b0; k++) @(negedge sys_clk);
    chk("din", ed, bus.data_in_strobe_n);
    @(negedge sys_clk);
    chk("done", 1'b1, done);
    chk("activate", ea, mem_act);
    chk("refresh seen", rf, ref_seen);
    chk("refresh active", rf, ref_act);
    creq = 1'b0;
  endtask
  // one dma tenure by the device end
  task dma(input logic hlt);
    xreq = 1'b1;
    for (k = 0; k < 20 && dma_act !== 1'b1; k++) @(negedge sys_clk);
    chk("dma active", 1'b1, dma_act);
    chk("master", 1'b1, master);
    chk("halted", hlt, halted);
    xreq = 1'b0;
    xdone = 1'b1;
    @(negedge sys_clk);
    xdone = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("released", 1'b0, dma_act);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    foreach (rows[i]) cyc(rows[i][3], rows[i][2], rows[i][1], rows[i][0]);
    xref = 1'b0;
    $display("table done");
    dma(1'b0);
    dma(1'b0);
    $display("dma back to back done");
    irq = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("irq taken", 1'b1, irq_tk);
    halt_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("halted", 1'b1, halted);
    chk("console", 1'b1, odt_run);
    chk("irq blocked", 1'b0, irq_tk);
    dma(1'b1);
    halt_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("resumed", 1'b0, halted);
    chk("irq again", 1'b1, irq_tk);
    $display("halt done");
    crd = 1'b0;
    creq = 1'b1;
    dma(1'b0);
    chk("done after dma", 1'b1, done);
    creq = 1'b0;
    $display("dma ahead of core done");
    xreq = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b1;
    xreq = 1'b0;
    @(negedge sys_clk);
    chk("reset grant", 1'b1, bus.dma_grant_out_n);
    chk("reset ack", 1'b1, bus.selection_ack_n);
    chk("reset master", 1'b0, master);
    chk("reset irq", 1'b0, irq_tk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("irq after reset", 1'b1, irq_tk);
    chk("idle after reset", 1'b0, dma_act);
    $display("reset done");
    end_of_test;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    error_cnt++;
    end_of_test;
  end
endmodule // tb_dma_halt_refresh_bus_control
